// File: common/mic_consts.svh
/*
  constants for the interrupt controller: register offsets, bit positions,
  reset values, vectors and acceptance timing.
  assumes inclusion by bare name from the package and the core.
*/
`ifndef MIC_CONSTS_SVH
`define MIC_CONSTS_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define MIC_OFS_STICKY_LOW 8'hf5
`define MIC_OFS_EN_HIGH 8'hf6
`define MIC_OFS_EN_MID 8'hf7
`define MIC_OFS_EN_LOW 8'hf8
`define MIC_OFS_REQ_HIGH 8'hf9
`define MIC_OFS_REQ_MID 8'hfa
`define MIC_OFS_REQ_LOW 8'hfb
`define MIC_OFS_EDGE_SEL 8'hfc
`define MIC_OFS_CTRL 8'hfd

// ------------------------------------------------------------
// implemented bits and reset values
// ------------------------------------------------------------
`define MIC_MASK_HIGH 8'hec
`define MIC_MASK_MID 8'hf3
`define MIC_MASK_LOW 8'h70
`define MIC_MASK_STICKY 8'hc7
`define MIC_MASK_EDGE 8'h3f
`define MIC_RST_REG 8'h00

// bit 2 of the status word is the master enable
`define MIC_PSW_IE_BIT 2
// control register bit 0: watchdog match resets rather than interrupts
`define MIC_CTRL_WDRST_BIT 0

// ------------------------------------------------------------
// vectors and timing
// ------------------------------------------------------------
`define MIC_VEC_TOP 16'hfffc
// fff6 and fff0 belong to sources that take no vector here
`define MIC_VEC_EXT0 16'hfffa
`define MIC_VEC_EXT1 16'hfff8
`define MIC_VEC_SER_RX 16'hfff4
`define MIC_VEC_SER_TX 16'hfff2
`define MIC_VEC_TMR_A 16'hffee
`define MIC_VEC_TMR_B 16'hffec
`define MIC_VEC_TMR_C 16'hffea
`define MIC_VEC_TMR_D 16'hffe8
`define MIC_VEC_CARRIER 16'hffe6
`define MIC_VEC_CONV 16'hffe4
`define MIC_VEC_INTERVAL 16'hffe2
`define MIC_VEC_WATCHDOG 16'hffe0
// watch timer entry taken as the next slot down; not fixed elsewhere
`define MIC_VEC_WATCH 16'hffde
`define MIC_ACCEPT_FOSC 8
// one fosc period taken as one system clock
`define MIC_ACCEPT_CYC (`MIC_ACCEPT_FOSC)

`endif

// File: common/mic_pkg.sv
/*
  types shared by the interrupt controller.
  assumes mic_consts.svh is on the include path.
*/
package mic_pkg;
  `include "mic_consts.svh"

  typedef struct packed {
    logic keyscan;
    logic ext0;
    logic ext1;
    logic serial_rx;
    logic serial_tx;
    logic timer_a;
    logic timer_b;
    logic timer_c;
    logic timer_d;
    logic carrier_gen;
    logic converter;
    logic interval_timer;
    logic watchdog;
    logic watch_timer;
  } mic_src_s;

  typedef enum logic [1:0] {
    MIC_EDGE_FALL = 2'b00,
    MIC_EDGE_RISE = 2'b01,
    MIC_EDGE_BOTH = 2'b10,
    MIC_EDGE_OFF = 2'b11
  } mic_edge_e;

  typedef enum logic [1:0] {
    MIC_IDLE = 2'b00,
    MIC_WAIT = 2'b01,
    MIC_DONE = 2'b10
  } mic_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } mic_bus_s;
endpackage

// File: core/mic_ctrl.sv
/*
  prioritised interrupt controller with register port and cpu handshake.
  assumes peripheral event inputs are one-cycle pulses on i_clk, the pins
  and key inputs are asynchronous, and the core pulses i_insn_done between
  instructions and i_push_done once the status word is stacked.
*/
// The plain strobed port was decided locally.
`timescale 1ns/1ps
// How it works
// - service needs request, enable and master enable
// - fixed priority, keyscan first, watch timer last
// - request flags set regardless of enable
// - external pins: falling, rising or both edges
// - keyscan request while selected key low
// - serial requests on character rx/tx done
// - timer requests on compare match
// - converter request on conversion done
// - interval timer request on overflow
// - watchdog request only when reset-select clear
// - watch timer request every interval
// - vectoring clears the accepted request of every source except keyscan
// - sticky bit set on request and enable
// - hardware never clears sticky bits
// - disabled source or master off blocks
// - accept: clear master, push, load vector
// - software reads and writes request flags
// - higher priority wins simultaneous requests
// - request held until accepted or cleared
// - acceptance takes eight cycles after instruction
module mic_ctrl
  import mic_pkg::*;
#(
  parameter int KEY_W = 8
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_ext_irq_pin_a,
  input wire logic i_ext_irq_pin_b,
  input wire logic i_ext_irq_pin_c,
  input wire logic [KEY_W-1:0] i_key_n,
  input wire logic [KEY_W-1:0] i_key_select,
  input wire logic i_serial_rx_done,
  input wire logic i_serial_tx_done,
  input wire logic [3:0] i_timer_match,
  input wire logic i_carrier_gen_event,
  input wire logic i_converter_done,
  input wire logic i_interval_overflow,
  input wire logic i_watchdog_match,
  input wire logic i_watch_tick,
  input wire logic [7:0] i_program_status_word,
  input wire logic i_insn_done,
  input wire logic i_push_done,
  output logic o_ext_c_flag,
  output logic o_watchdog_reset,
  output logic o_accept,
  output logic o_clear_master,
  output logic o_push_req,
  output logic [15:0] o_vector,
  output logic o_vector_valid
);
  `include "mic_consts.svh"

  if (KEY_W < 1 || KEY_W > 8) begin : bad_key_w
    $error("mic_ctrl: KEY_W must be 1..8");
  end

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic [2:0] pin_prev;
  logic [KEY_W-1:0] key_meta;
  logic [KEY_W-1:0] key_sync;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pin_meta <= 3'h7;
      pin_sync <= 3'h7;
      pin_prev <= 3'h7;
      key_meta <= '1;
      key_sync <= '1;
    end else begin
      pin_meta <= {i_ext_irq_pin_c, i_ext_irq_pin_b, i_ext_irq_pin_a};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
      key_meta <= i_key_n;
      key_sync <= key_meta;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] irq_enable_high;
  logic [7:0] irq_enable_middle;
  logic [7:0] irq_enable_low;
  logic [7:0] edge_select_reg;
  logic [7:0] ctrl_reg;
  mic_src_s req;
  mic_src_s sticky;
  logic ext_c_flag;
  mic_src_s enable;
  mic_src_s set_evt;
  mic_src_s sw_clr;
  mic_src_s hw_clr;
  mic_src_s sticky_sw_clr;

  function automatic logic edge_hit(input logic [1:0] sel, input logic now,
                                    input logic was);
    edge_hit = (sel == MIC_EDGE_FALL && was && !now) ||
               (sel == MIC_EDGE_RISE && !was && now) ||
               (sel == MIC_EDGE_BOTH && was != now);
  endfunction

  wire wr_high = i_wr && i_addr == `MIC_OFS_REQ_HIGH;
  wire wr_mid = i_wr && i_addr == `MIC_OFS_REQ_MID;
  wire wr_low = i_wr && i_addr == `MIC_OFS_REQ_LOW;
  wire wr_sticky = i_wr && i_addr == `MIC_OFS_STICKY_LOW;
  wire [2:0] ext_hit = {edge_hit(edge_select_reg[5:4], pin_sync[2], pin_prev[2]),
                        edge_hit(edge_select_reg[3:2], pin_sync[1], pin_prev[1]),
                        edge_hit(edge_select_reg[1:0], pin_sync[0], pin_prev[0])};
  wire key_low = |(~key_sync & i_key_select);
  wire wd_irq = i_watchdog_match && !ctrl_reg[`MIC_CTRL_WDRST_BIT];

  assign enable = '{keyscan: irq_enable_high[7], ext0: irq_enable_high[6],
                    ext1: irq_enable_high[5], serial_rx: irq_enable_high[3],
                    serial_tx: irq_enable_high[2], timer_a: irq_enable_middle[7],
                    timer_b: irq_enable_middle[6], timer_c: irq_enable_middle[5],
                    timer_d: irq_enable_middle[4], carrier_gen: irq_enable_middle[1],
                    converter: irq_enable_middle[0], interval_timer: irq_enable_low[6],
                    watchdog: irq_enable_low[5], watch_timer: irq_enable_low[4]};

  // flags set by events regardless of enable
  assign set_evt = '{keyscan: key_low, ext0: ext_hit[0], ext1: ext_hit[1],
                     serial_rx: i_serial_rx_done, serial_tx: i_serial_tx_done,
                     timer_a: i_timer_match[0], timer_b: i_timer_match[1],
                     timer_c: i_timer_match[2], timer_d: i_timer_match[3],
                     carrier_gen: i_carrier_gen_event,
                     converter: i_converter_done,
                     interval_timer: i_interval_overflow,
                     watchdog: wd_irq, watch_timer: i_watch_tick};

  // software writes of zero clear request bits
  assign sw_clr = '{keyscan: wr_high && !i_wdata[7], ext0: wr_high && !i_wdata[6],
                    ext1: wr_high && !i_wdata[5], serial_rx: wr_high && !i_wdata[3],
                    serial_tx: wr_high && !i_wdata[2], timer_a: wr_mid && !i_wdata[7],
                    timer_b: wr_mid && !i_wdata[6], timer_c: wr_mid && !i_wdata[5],
                    timer_d: wr_mid && !i_wdata[4], carrier_gen: wr_mid && !i_wdata[1],
                    converter: wr_mid && !i_wdata[0], interval_timer: wr_low && !i_wdata[6],
                    watchdog: wr_low && !i_wdata[5], watch_timer: wr_low && !i_wdata[4]};
  wire [13:0] sw_set = {wr_high && i_wdata[7], wr_high && i_wdata[6], wr_high && i_wdata[5],
                        wr_high && i_wdata[3], wr_high && i_wdata[2], wr_mid && i_wdata[7],
                        wr_mid && i_wdata[6], wr_mid && i_wdata[5], wr_mid && i_wdata[4],
                        wr_mid && i_wdata[1], wr_mid && i_wdata[0], wr_low && i_wdata[6],
                        wr_low && i_wdata[5], wr_low && i_wdata[4]};

  // only the timer c/d, converter, watch, watchdog stickies exist in software view
  assign sticky_sw_clr = '{timer_c: wr_sticky && !i_wdata[7],
                           timer_d: wr_sticky && !i_wdata[6],
                           converter: wr_sticky && !i_wdata[2],
                           watch_timer: wr_sticky && !i_wdata[1],
                           watchdog: wr_sticky && !i_wdata[0], default: 1'b0};

  // ------------------------------------------------------------
  // priority and acceptance
  // ------------------------------------------------------------
  mic_state_e state;
  mic_state_e next_state;
  logic [3:0] wait_cnt;
  logic [3:0] grant_idx;
  logic [15:0] vector;
  logic vector_valid;
  wire master_on = i_program_status_word[`MIC_PSW_IE_BIT];
  wire [13:0] pend = req & enable;
  wire any_pend = master_on && |pend;

  // msb of the packed struct is keyscan, the top priority
  function automatic logic [3:0] top_idx(input logic [13:0] p);
    top_idx = 4'h0;
    for (int i = 0; i < 14; i++) begin
      if (p[13-i] && top_idx == 4'h0) begin
        top_idx = 4'(i + 1);
      end
    end
  endfunction

  // the table has holes, so no stepping formula fits it
  function automatic logic [15:0] vec_of(input logic [3:0] lvl);
    unique case (lvl)
      4'h1: vec_of = `MIC_VEC_TOP;
      4'h2: vec_of = `MIC_VEC_EXT0;
      4'h3: vec_of = `MIC_VEC_EXT1;
      4'h4: vec_of = `MIC_VEC_SER_RX;
      4'h5: vec_of = `MIC_VEC_SER_TX;
      4'h6: vec_of = `MIC_VEC_TMR_A;
      4'h7: vec_of = `MIC_VEC_TMR_B;
      4'h8: vec_of = `MIC_VEC_TMR_C;
      4'h9: vec_of = `MIC_VEC_TMR_D;
      4'ha: vec_of = `MIC_VEC_CARRIER;
      4'hb: vec_of = `MIC_VEC_CONV;
      4'hc: vec_of = `MIC_VEC_INTERVAL;
      4'hd: vec_of = `MIC_VEC_WATCHDOG;
      4'he: vec_of = `MIC_VEC_WATCH;
      default: vec_of = `MIC_VEC_TOP;
    endcase
  endfunction

  wire [3:0] best = top_idx(pend);
  wire accept_now = state == MIC_WAIT && wait_cnt == 4'(`MIC_ACCEPT_CYC - 1);
  wire [13:0] grant_oh = accept_now ? (14'h2000 >> (grant_idx - 4'h1)) : 14'h0;
  // keyscan is level driven so it keeps its flag
  assign hw_clr = grant_oh & 14'h1fff;

  always_comb begin
    next_state = state;
    unique case (state)
      MIC_IDLE: begin
        if (i_insn_done && any_pend) begin
          next_state = MIC_WAIT;
        end
      end
      MIC_WAIT: begin
        if (accept_now) begin
          next_state = MIC_DONE;
        end
      end
      MIC_DONE: begin
        if (i_push_done) begin
          next_state = MIC_IDLE;
        end
      end
      default: next_state = MIC_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= MIC_IDLE;
      wait_cnt <= 4'h0;
      grant_idx <= 4'h0;
      vector <= 16'h0000;
      vector_valid <= 1'b0;
    end else begin
      state <= next_state;
      wait_cnt <= (state == MIC_WAIT) ? wait_cnt + 4'h1 : 4'h0;
      if (state == MIC_IDLE && i_insn_done && any_pend) begin
        grant_idx <= best;
      end
      if (accept_now) begin
        vector <= vec_of(grant_idx);
      end
      vector_valid <= (state == MIC_DONE && !i_push_done) || accept_now;
    end
  end

  assign o_accept = accept_now;
  assign o_clear_master = accept_now;
  assign o_push_req = state == MIC_DONE;
  assign o_vector = vector;
  assign o_vector_valid = vector_valid;

  // ------------------------------------------------------------
  // flag and register state
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      req <= '0;
      sticky <= '0;
      ext_c_flag <= 1'b0;
      irq_enable_high <= `MIC_RST_REG;
      irq_enable_middle <= `MIC_RST_REG;
      irq_enable_low <= `MIC_RST_REG;
      edge_select_reg <= `MIC_RST_REG;
      ctrl_reg <= `MIC_RST_REG;
    end else begin
      // set wins over both clears; held until cleared
      req <= set_evt | sw_set | (req & ~sw_clr & ~hw_clr);
      // level view: a flag enabled later still marks it; no hardware clear
      sticky <= (req & enable) | (sticky & ~sticky_sw_clr);
      ext_c_flag <= ext_hit[2] | (ext_c_flag & !(wr_high && !i_wdata[4]));
      if (i_wr && i_addr == `MIC_OFS_EN_HIGH) begin
        irq_enable_high <= i_wdata & `MIC_MASK_HIGH;
      end
      if (i_wr && i_addr == `MIC_OFS_EN_MID) begin
        irq_enable_middle <= i_wdata & `MIC_MASK_MID;
      end
      if (i_wr && i_addr == `MIC_OFS_EN_LOW) begin
        irq_enable_low <= i_wdata & `MIC_MASK_LOW;
      end
      if (i_wr && i_addr == `MIC_OFS_EDGE_SEL) begin
        edge_select_reg <= i_wdata & `MIC_MASK_EDGE;
      end
      if (i_wr && i_addr == `MIC_OFS_CTRL) begin
        ctrl_reg <= {7'h0, i_wdata[0]};
      end
    end
  end

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  wire [7:0] rd_high = {req.keyscan, req.ext0, req.ext1, ext_c_flag,
                        req.serial_rx, req.serial_tx, 2'b00};
  wire [7:0] rd_mid = {req.timer_a, req.timer_b, req.timer_c, req.timer_d,
                       2'b00, req.carrier_gen, req.converter};
  wire [7:0] rd_low = {1'b0, req.interval_timer, req.watchdog, req.watch_timer, 4'h0};
  wire [7:0] rd_sticky = {sticky.timer_c, sticky.timer_d, 3'h0,
                          sticky.converter, sticky.watch_timer, sticky.watchdog};
  // unmapped addresses read zero
  wire [7:0] rd_mux = (i_addr == `MIC_OFS_STICKY_LOW) ? rd_sticky :
                      (i_addr == `MIC_OFS_EN_HIGH) ? irq_enable_high :
                      (i_addr == `MIC_OFS_EN_MID) ? irq_enable_middle :
                      (i_addr == `MIC_OFS_EN_LOW) ? irq_enable_low :
                      (i_addr == `MIC_OFS_REQ_HIGH) ? rd_high :
                      (i_addr == `MIC_OFS_REQ_MID) ? rd_mid :
                      (i_addr == `MIC_OFS_REQ_LOW) ? rd_low :
                      (i_addr == `MIC_OFS_EDGE_SEL) ? edge_select_reg :
                      (i_addr == `MIC_OFS_CTRL) ? ctrl_reg : 8'h00;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= 8'h00;
      o_ext_c_flag <= 1'b0;
      o_watchdog_reset <= 1'b0;
    end else begin
      o_rdata <= i_rd ? rd_mux : 8'h00;
      o_ext_c_flag <= ext_c_flag;
      o_watchdog_reset <= i_watchdog_match && ctrl_reg[`MIC_CTRL_WDRST_BIT];
    end
  end
endmodule // mic_ctrl

// File: verif/mic_ctrl_asserts.sv
/*
  port checker for the interrupt controller: handshake, vector and read port.
  assumes it is bound onto mic_ctrl, one clock, reset active low.
*/
`timescale 1ns/1ps
module mic_ctrl_asserts
  import mic_pkg::*;
#(
  parameter int KEY_W = 8
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic i_watchdog_match,
  input wire logic [7:0] i_program_status_word,
  input wire logic i_insn_done,
  input wire logic i_push_done,
  input wire logic o_watchdog_reset,
  input wire logic o_accept,
  input wire logic o_clear_master,
  input wire logic o_push_req,
  input wire logic [15:0] o_vector,
  input wire logic o_vector_valid
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  // ----------------------------------------
  // acceptance handshake
  // ----------------------------------------
  accept_clears_a: assert property (o_accept |-> o_clear_master)
    else $error("accept without master clear");
  clear_alone_a: assert property (o_clear_master |-> o_accept)
    else $error("master clear without accept");
  accept_delay_a: assert property (o_accept |-> $past(i_insn_done, 8))
    else $error("accept not eight cycles after boundary");
  master_gate_a: assert property (o_accept |-> $past(i_program_status_word[2], 8))
    else $error("accept taken with master enable off");
  push_follow_a: assert property (o_accept |=> o_push_req && o_vector_valid)
    else $error("no push request after accept");
  push_hold_a: assert property (o_push_req && !i_push_done |=> o_push_req)
    else $error("push request dropped early");
  push_drop_a: assert property (o_push_req && i_push_done |=> !o_push_req)
    else $error("push request held after done");
  vector_range_a: assert property (o_vector_valid |->
    o_vector[0] == 1'b0 && o_vector <= 16'hfffc && o_vector >= 16'hffde)
    else $error("vector outside table");
  vector_steady_a: assert property (o_vector_valid && $past(o_vector_valid) |-> $stable(o_vector))
    else $error("vector changed while held");
  rdata_quiet_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside read slot");
  wd_reset_a: assert property (o_watchdog_reset |-> $past(i_watchdog_match))
    else $error("watchdog reset without match");

  cover property (o_accept);
  cover property (o_watchdog_reset);
  cover property (o_push_req && i_push_done);
endmodule // mic_ctrl_asserts

bind mic_ctrl mic_ctrl_asserts #(.KEY_W(KEY_W)) mic_ctrl_asserts_inst (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_watchdog_match(i_watchdog_match), .i_program_status_word(i_program_status_word),
  .i_insn_done(i_insn_done), .i_push_done(i_push_done), .o_watchdog_reset(o_watchdog_reset),
  .o_accept(o_accept), .o_clear_master(o_clear_master), .o_push_req(o_push_req),
  .o_vector(o_vector), .o_vector_valid(o_vector_valid));

// File: verif/mic_cpu_model.sv
/*
  model of the cpu core: instruction boundaries and stacking on accept.
  assumes the controller's clock and reset; i_slow lengthens stacking.
*/
`timescale 1ns/1ps
module mic_cpu_model (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_push_req,
  input wire logic i_slow,
  output logic o_insn_done,
  output logic o_push_done
);
  logic [1:0] insn_cnt;
  logic [2:0] push_cnt;

  // boundary every fourth cycle, none while stacking
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      insn_cnt <= 2'h0;
      o_insn_done <= 1'b0;
    end else begin
      insn_cnt <= insn_cnt + 2'h1;
      o_insn_done <= (insn_cnt == 2'h3) && !i_push_req;
    end
  end

  // done pulses once; slow stacking probes the held request
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      push_cnt <= 3'h0;
      o_push_done <= 1'b0;
    end else if (i_push_req && !o_push_done) begin
      push_cnt <= push_cnt + 3'h1;
      o_push_done <= push_cnt == (i_slow ? 3'h5 : 3'h1);
    end else begin
      push_cnt <= 3'h0;
      o_push_done <= 1'b0;
    end
  end
endmodule // mic_cpu_model

// File: verif/mic_ctrl_bench.sv
/*
  self-checking bench for mic_ctrl: register port, event sources, acceptance.
  assumes mic_cpu_model stands in for the core.
*/
`timescale 1ns/1ps
`define CHK(g, e) check_val((g), (e))
module mic_ctrl_bench;
  import mic_pkg::*;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic pin = 1'b1;
  logic [7:0] key_n = 8'hff;
  logic [7:0] key_sel = 8'h00;
  logic [10:0] ev = 11'h000;
  logic [7:0] program_status_word = 8'h00;
  logic slow = 1'b0;
  logic [7:0] o_rdata;
  logic [15:0] o_vector;
  logic o_ext_c_flag, o_watchdog_reset, o_accept, o_clear_master, o_push_req, o_vector_valid;
  logic insn_done, push_done;
  int fails = 0;
  int n_compared = 0;
  int n_acc = 0;
  logic [15:0] vecs [3] = '{16'hffee, 16'hffe8, 16'hffe0};

  always #2.5 i_clk = ~i_clk;
  always @(negedge i_clk) if (o_accept === 1'b1) n_acc++;

  mic_ctrl mic_ctrl_inst (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr_s), .i_rd(rd_s), .o_rdata(o_rdata), .i_ext_irq_pin_a(pin), .i_ext_irq_pin_b(pin),
    .i_ext_irq_pin_c(pin), .i_key_n(key_n), .i_key_select(key_sel),
    .i_serial_rx_done(ev[10]), .i_serial_tx_done(ev[9]), .i_timer_match(ev[8:5]),
    .i_carrier_gen_event(ev[4]), .i_converter_done(ev[3]), .i_interval_overflow(ev[2]),
    .i_watchdog_match(ev[1]), .i_watch_tick(ev[0]), .i_program_status_word(program_status_word),
    .i_insn_done(insn_done), .i_push_done(push_done), .o_ext_c_flag(o_ext_c_flag),
    .o_watchdog_reset(o_watchdog_reset), .o_accept(o_accept), .o_clear_master(o_clear_master),
    .o_push_req(o_push_req), .o_vector(o_vector), .o_vector_valid(o_vector_valid));
  mic_cpu_model mic_cpu_model_inst (.i_clk(i_clk), .i_rstn(i_rstn), .i_push_req(o_push_req),
    .i_slow(slow), .o_insn_done(insn_done), .o_push_done(push_done));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge i_clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
    @(posedge i_clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge i_clk);
    rd_s <= 1'b0;
    #1;
    `CHK(o_rdata & m, e);
  endtask
  task automatic ev_pulse(input logic [10:0] v);
    @(posedge i_clk);
    ev <= v;
    @(posedge i_clk);
    ev <= 11'h000;
    #1;
  endtask
  task automatic settle(input logic p, input logic [7:0] k);
    @(posedge i_clk);
    pin <= p;
    key_n <= k;
    repeat (4) @(posedge i_clk);
  endtask
  task automatic wait_accept(input logic [15:0] v);
    int k;
    k = 0;
    while (o_accept !== 1'b1 && k < 100) begin
      @(posedge i_clk);
      #1;
      k++;
    end
    if (k == 100) begin
      fails++;
      give_verdict();
    end else begin
      `CHK(o_clear_master, 1'b1);
      @(posedge i_clk);
      #1;
      `CHK({o_push_req, o_vector_valid, o_vector}, {2'b11, v});
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge i_clk);
    i_rstn <= 1'b1;
    for (int a = 8'hf5; a <= 8'hfd; a++) rd(8'(a), 8'h00);
    wr(8'h40, 8'hff);
    rd(8'h40, 8'h00);
    wr(8'hf6, 8'hff);
    rd(8'hf6, 8'hec);
    wr(8'hf6, 8'h00);
    $display("registers done");
    // sources flag with every enable off
    ev_pulse(11'h7ff);
    rd(8'hf9, 8'h0c, 8'hef);
    rd(8'hfa, 8'hf3);
    rd(8'hfb, 8'h70);
    rd(8'hf5, 8'h00);
    wr(8'hf9, 8'h00);
    wr(8'hfa, 8'h00);
    wr(8'hfb, 8'h00);
    rd(8'hfa, 8'h00);
    wr(8'hfb, 8'h70);
    rd(8'hfb, 8'h70);
    wr(8'hfb, 8'h00);
    wr(8'hf7, 8'hff);
    wr(8'hf8, 8'hff);
    ev_pulse(11'h7ff);
    rd(8'hf5, 8'hc7);
    wr(8'hf5, 8'hff);
    rd(8'hf5, 8'hc7);
    fork
      wr(8'hfa, 8'h00);
      ev_pulse(11'h020);
    join
    rd(8'hfa, 8'h80);
    wr(8'hfa, 8'h00);
    wr(8'hfb, 8'h00);
    $display("flags done");
    for (int m = 0; m < 4; m++) begin
      wr(8'hfc, {2'b00, 2'(m), 2'(m), 2'(m)});
      wr(8'hf9, 8'h00);
      settle(1'b0, 8'hff);
      rd(8'hf9, (m == 0 || m == 2) ? 8'h60 : 8'h00, 8'hef);
      `CHK(o_ext_c_flag, m == 0 || m == 2);
      wr(8'hf9, 8'h00);
      settle(1'b1, 8'hff);
      rd(8'hf9, (m == 1 || m == 2) ? 8'h60 : 8'h00, 8'hef);
      `CHK(o_ext_c_flag, m == 1 || m == 2);
    end
    wr(8'hfc, 8'h3f);
    wr(8'hf9, 8'h00);
    @(posedge i_clk);
    key_sel <= 8'h01;
    settle(1'b1, 8'hfd);
    rd(8'hf9, 8'h00, 8'hef);
    settle(1'b1, 8'hfe);
    rd(8'hf9, 8'h80, 8'hef);
    settle(1'b1, 8'hff);
    wr(8'hf9, 8'h00);
    $display("pins done");
    wr(8'hfd, 8'h01);
    ev_pulse(11'h002);
    `CHK(o_watchdog_reset, 1'b1);
    rd(8'hfb, 8'h00);
    wr(8'hfd, 8'h00);
    wr(8'hf5, 8'h00);
    ev_pulse(11'h122);
    repeat (20) @(posedge i_clk);
    `CHK(n_acc, 0);
    @(posedge i_clk);
    program_status_word <= 8'h04;
    for (int i = 0; i < 3; i++) begin
      slow <= (i == 1);
      wait_accept(vecs[i]);
    end
    @(posedge i_clk);
    program_status_word <= 8'h00;
    repeat (10) @(posedge i_clk);
    rd(8'hfa, 8'h00);
    rd(8'hfb, 8'h00);
    rd(8'hf5, 8'h41);
    $display("acceptance done");
    give_verdict();
  end
endmodule // mic_ctrl_bench
